// ### ccr_channel_regs.vh
// Operation
// - Command LSB: 0 write, 1 read
// - Gain bit5 receive loss; reset zero
// - Gain low five bits: scaling code
// - Code 10000 loopback, code zero cutoff
// - Data latched; pins driven only as outputs
// - Bit5 mux detect; bits 7,6 output-only
// - Top two control pins always outputs
// - Direction bits 4..0: 0 input, 1 output
// - Direction bit6 channel active, read-only
// - Direction bit5 global clock-sync-lost flag
// - Direction bit7 reserved, write zero
// - Bit7 linear coding, bit6 mu-law
// - Bits 5..0 choose filter coefficient source
// - Mask bit per detect bit gates interrupt
// - Mask ignores channel enable; resets all ones
// - Reset clears gain, data, direction, functions
// - Per-channel commands act only on enabled channels; mask, enable and detect commands are global
// - Two detect bits per channel
`ifndef CCR_CHANNEL_REGS_VH
`define CCR_CHANNEL_REGS_VH
`define CCR_CMD_GAIN      8'h50
`define CCR_CMD_LINEDATA  8'h52
`define CCR_CMD_DIR       8'h54
`define CCR_CMD_OPFUNC    8'h60
`define CCR_CMD_MASK      8'h6c
`define CCR_CMD_CHANEN    8'h4a
`define CCR_CMD_RTDATA    8'h4d
`define CCR_CMD_RTCLEAR   8'h4f
`define CCR_RW_BIT        0
`define CCR_RST_ZERO      8'h00
`define CCR_RST_MASK      8'hff
`define CCR_RST_CHANEN    4'hf
`define CCR_RST_SYNC      33'h180000000
`define CCR_CODE_LOOPBACK 5'h10
`define CCR_CODE_CUTOFF   5'h00
`define CCR_DIR_ACTIVE    6
`define CCR_DIR_CLKFAIL   5
`define CCR_PIN_DETECT1   0
`define CCR_PIN_DETECT2   1
`endif

// ### ccr_channel_regs.v
`timescale 1ns/1ps
`include "ccr_channel_regs.vh"
module ccr_channel_regs (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        mpiClk,
  input  wire        mpiCsN,
  input  wire        mpiDin,
  input  wire [19:0] linePinIn,
  input  wire [3:0]  muxSecondDetect,
  input  wire        e1MuxEnable,
  input  wire [3:0]  chanActive,
  input  wire        clockSyncLost,
  output reg         mpiDout,
  output reg         mpiDoutEn,
  output reg         intPinOut,
  output reg         intPinOe,
  output wire [31:0] gainCfg,
  output wire [31:0] opFuncCfg,
  output wire [3:0]  loopbackEn,
  output wire [3:0]  scalingCutoff,
  output wire [19:0] linePinOut,
  output wire [19:0] linePinOe,
  output wire [7:0]  ctrlPinOut
);
  localparam ST_CMD   = 3'b001;
  localparam ST_WDATA = 3'b010;
  localparam ST_RDATA = 3'b100;

  // Every input but the clock and reset passes two flops before use
  wire [32:0] rawIn = {mpiClk, mpiCsN, mpiDin, linePinIn, muxSecondDetect,
                       e1MuxEnable, chanActive, clockSyncLost};
  reg  [32:0] syncA_reg;
  reg  [32:0] syncB_reg;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      // Serial clock and select start at their idle high level
      syncA_reg <= `CCR_RST_SYNC;
      syncB_reg <= `CCR_RST_SYNC;
    end else begin
      syncA_reg <= rawIn;
      syncB_reg <= syncA_reg;
    end
  end
  wire        sClk      = syncB_reg[32];
  wire        sCsN      = syncB_reg[31];
  wire        sDin      = syncB_reg[30];
  wire [19:0] sPin      = syncB_reg[29:10];
  wire [3:0]  sMux      = syncB_reg[9:6];
  wire        sE1       = syncB_reg[5];
  wire [3:0]  sActive   = syncB_reg[4:1];
  wire        sClkFail  = syncB_reg[0];

  // Read copies; each channel drives only its own element
  wire [7:0]  gainReg   [0:3];
  wire [7:0]  dataReg   [0:3];
  wire [4:0]  dirReg    [0:3];
  wire [7:0]  opReg     [0:3];

  // Global registers
  reg  [7:0]  maskReg;
  reg  [3:0]  chanEnReg;

  reg         clkPrev_reg;
  reg  [2:0]  bitCnt_reg;
  reg  [7:0]  shiftIn_reg;
  reg  [7:0]  shiftOut_reg;
  reg  [7:0]  cmd_reg;
  reg  [2:0]  phase_reg;

  reg         wrStrobe;
  reg  [7:0]  wrData;
  reg         clrStrobe;
  reg  [7:0]  detPrev_reg;

  // Edges of the synchronised serial clock
  wire       clkRise  = sClk & ~clkPrev_reg;
  wire       clkFall  = ~sClk & clkPrev_reg;
  wire [7:0] byteNext = {shiftIn_reg[6:0], sDin};
  // Eighth rise of a byte while selected
  wire       byteDone = clkRise & ~sCsN & (bitCnt_reg == 3'h7);

  // Lowest enabled channel answers a per-channel read
  reg  [1:0] selCh;
  reg        anyEn;
  always @* begin
    anyEn = |chanEnReg;
    if (chanEnReg[0]) begin
      selCh = 2'h0;
    end else if (chanEnReg[1]) begin
      selCh = 2'h1;
    end else if (chanEnReg[2]) begin
      selCh = 2'h2;
    end else begin
      selCh = 2'h3;
    end
  end

  // Detect bits, two per channel, channel 0 low
  wire [7:0] detect;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gDet
      assign detect[g*2]   = sPin[g*5+`CCR_PIN_DETECT1];
      assign detect[g*2+1] = sE1 ? sMux[g] : sPin[g*5+`CCR_PIN_DETECT2];
    end
  endgenerate

  // Read byte chosen as the command's last bit arrives
  reg [7:0] readByte;
  always @* begin
    readByte = 8'h00;
    if (byteNext == `CCR_CMD_RTDATA || byteNext == `CCR_CMD_RTCLEAR) begin
      readByte = detect;
    end else if (byteNext == (`CCR_CMD_MASK | 8'h01)) begin
      readByte = maskReg;
    end else if (byteNext == (`CCR_CMD_CHANEN | 8'h01)) begin
      readByte = {4'h0, chanEnReg};
    end else if (byteNext == (`CCR_CMD_DIR | 8'h01)) begin
      // Clock flag reported even with no channel enabled
      readByte = {1'b0, sActive[selCh] & anyEn, sClkFail,
                  anyEn ? dirReg[selCh] : 5'h00};
    end else if (!anyEn) begin
      readByte = 8'h00;
    end else if (byteNext == (`CCR_CMD_GAIN | 8'h01)) begin
      readByte = gainReg[selCh];
    end else if (byteNext == (`CCR_CMD_LINEDATA | 8'h01)) begin
      readByte = dataReg[selCh];
    end else if (byteNext == (`CCR_CMD_OPFUNC | 8'h01)) begin
      readByte = opReg[selCh];
    end
  end

  // Unknown write commands take no data byte
  wire isWriteCmd = (byteNext == `CCR_CMD_GAIN) || (byteNext == `CCR_CMD_LINEDATA) ||
                    (byteNext == `CCR_CMD_DIR) || (byteNext == `CCR_CMD_OPFUNC) ||
                    (byteNext == `CCR_CMD_MASK) || (byteNext == `CCR_CMD_CHANEN);

  // Serial command engine, MSB first, sampled on rising clock
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clkPrev_reg  <= 1'b1;
      bitCnt_reg   <= 3'h0;
      shiftIn_reg  <= 8'h00;
      shiftOut_reg <= 8'h00;
      cmd_reg      <= 8'h00;
      phase_reg    <= ST_CMD;
      wrStrobe     <= 1'b0;
      wrData       <= 8'h00;
      clrStrobe    <= 1'b0;
      mpiDout      <= 1'b0;
      mpiDoutEn    <= 1'b0;
    end else begin
      clkPrev_reg <= sClk;
      wrStrobe    <= 1'b0;
      clrStrobe   <= 1'b0;
      if (sCsN) begin
        // Deselect aborts any partial byte
        bitCnt_reg <= 3'h0;
        phase_reg  <= ST_CMD;
        mpiDoutEn  <= 1'b0;
      end else begin
        if (clkRise) begin
          shiftIn_reg <= byteNext;
          bitCnt_reg  <= bitCnt_reg + 3'h1;
        end
        // Data moves on the fall, settled long before the host samples
        if (clkFall && phase_reg == ST_RDATA) begin
          mpiDout      <= shiftOut_reg[7];
          shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
        end
        if (byteDone) begin
          case (phase_reg)
            ST_CMD: begin
              cmd_reg <= byteNext;
              if (byteNext[`CCR_RW_BIT]) begin
                phase_reg    <= ST_RDATA;
                shiftOut_reg <= readByte;
                mpiDoutEn    <= 1'b1;
                clrStrobe    <= (byteNext == `CCR_CMD_RTCLEAR);
              end else if (isWriteCmd) begin
                phase_reg <= ST_WDATA;
              end
            end
            ST_WDATA: begin
              // Target register loads on the next cycle
              wrStrobe  <= 1'b1;
              wrData    <= byteNext;
              phase_reg <= ST_CMD;
            end
            ST_RDATA: begin
              phase_reg <= ST_CMD;
              mpiDoutEn <= 1'b0;
            end
            default: begin
              phase_reg <= ST_CMD;
            end
          endcase
        end
      end
    end
  end

  // Global registers, independent of channel enables
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      maskReg     <= `CCR_RST_MASK;
      chanEnReg   <= `CCR_RST_CHANEN;
      detPrev_reg <= 8'h00;
      intPinOe    <= 1'b0;
      intPinOut   <= 1'b0;
    end else begin
      // Open drain: the pin is only ever pulled low
      intPinOut   <= 1'b0;
      // Edge detect on the synchronised detect bits
      detPrev_reg <= detect;
      if (wrStrobe && cmd_reg == `CCR_CMD_MASK) begin
        maskReg <= wrData;
      end
      if (wrStrobe && cmd_reg == `CCR_CMD_CHANEN) begin
        chanEnReg <= wrData[3:0];
      end
      // New change wins over a simultaneous clear
      if (|((detect ^ detPrev_reg) & ~maskReg)) begin
        intPinOe <= 1'b1;
      end else if (clrStrobe) begin
        intPinOe <= 1'b0;
      end
    end
  end

  // Per-channel registers; each channel owns its flops and feeds one
  // element of the read copies, so every element has a single driver
  generate
    for (g = 0; g < 4; g = g + 1) begin : gCh
      wire       chWr = wrStrobe & chanEnReg[g];
      reg  [7:0] chGain_reg;
      reg  [7:0] chData_reg;
      reg  [4:0] chDir_reg;
      reg  [7:0] chOp_reg;
      reg        loopReg;
      reg        cutReg;
      reg  [4:0] pinOutReg;
      reg  [4:0] pinOeReg;
      reg  [1:0] ctrlReg;

      // Configuration bytes written over the serial port
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          chGain_reg <= `CCR_RST_ZERO;
          chData_reg <= `CCR_RST_ZERO;
          chDir_reg  <= 5'h00;
          chOp_reg   <= `CCR_RST_ZERO;
        end else begin
          if (chWr && cmd_reg == `CCR_CMD_GAIN) begin
            chGain_reg <= wrData;
          end
          if (chWr && cmd_reg == `CCR_CMD_LINEDATA) begin
            chData_reg <= wrData;
          end
          if (chWr && cmd_reg == `CCR_CMD_DIR) begin
            chDir_reg <= wrData[4:0];
          end
          if (chWr && cmd_reg == `CCR_CMD_OPFUNC) begin
            chOp_reg <= wrData;
          end
        end
      end

      // Decoded controls lag the byte by one cycle to stay on flops
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          loopReg   <= 1'b0;
          cutReg    <= 1'b1;
          pinOutReg <= 5'h00;
          pinOeReg  <= 5'h00;
          ctrlReg   <= 2'h0;
        end else begin
          loopReg   <= (chGain_reg[4:0] == `CCR_CODE_LOOPBACK);
          cutReg    <= (chGain_reg[4:0] == `CCR_CODE_CUTOFF);
          pinOutReg <= chData_reg[4:0];
          pinOeReg  <= chDir_reg;
          ctrlReg   <= chData_reg[7:6];
        end
      end

      // Read copies for the serial read mux
      assign gainReg[g] = chGain_reg;
      assign dataReg[g] = chData_reg;
      assign dirReg[g]  = chDir_reg;
      assign opReg[g]   = chOp_reg;

      assign gainCfg[g*8+:8]    = chGain_reg;
      assign opFuncCfg[g*8+:8]  = chOp_reg;
      assign loopbackEn[g]      = loopReg;
      assign scalingCutoff[g]   = cutReg;
      assign linePinOut[g*5+:5] = pinOutReg;
      assign linePinOe[g*5+:5]  = pinOeReg;
      assign ctrlPinOut[g*2+:2] = ctrlReg;
    end
  endgenerate
endmodule

// ### ccr_channel_regs_chk.sv
`timescale 1ns/1ps
module ccr_channel_regs_chk (
  input logic        sys_clk,
  input logic        nrst,
  input logic        mpiClk,
  input logic        mpiCsN,
  input logic [19:0] linePinIn,
  input logic [3:0]  muxSecondDetect,
  input logic        e1MuxEnable,
  input logic        mpiDout,
  input logic        mpiDoutEn,
  input logic        intPinOut,
  input logic        intPinOe,
  input logic [31:0] gainCfg,
  input logic [3:0]  loopbackEn,
  input logic [3:0]  scalingCutoff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_loop; loopbackEn[0] == ($past(gainCfg[4:0]) == 5'h10); endproperty
  a_loop: assert property (p_loop) else $error("loopback flag off");
  property p_cut; scalingCutoff[2] == ($past(gainCfg[20:16]) == 5'h00); endproperty
  a_cut: assert property (p_cut) else $error("cutoff flag off");
  property p_odrain; intPinOut == 1'b0; endproperty
  a_odrain: assert property (p_odrain) else $error("interrupt pin driven high");
  // Input synchronizer puts the cause 2 to 5 cycles back
  property p_rise;
    $rose(intPinOe) |->
      {$past(linePinIn, 2), $past(muxSecondDetect, 2), $past(e1MuxEnable, 2)} !=
      {$past(linePinIn, 5), $past(muxSecondDetect, 5), $past(e1MuxEnable, 5)};
  endproperty
  a_rise: assert property (p_rise) else $error("interrupt without cause");
  property p_clr; $fell(intPinOe) |-> !mpiCsN; endproperty
  a_clr: assert property (p_clr) else $error("interrupt dropped outside access");
  property p_doe; mpiDoutEn |-> !$past(mpiCsN, 4); endproperty
  a_doe: assert property (p_doe) else $error("read drive while deselected");
  property p_dout;
    mpiDoutEn && $past(mpiDoutEn) && $changed(mpiDout)
      |-> !$past(mpiClk, 2) || !$past(mpiClk, 3) || !$past(mpiClk, 4);
  endproperty
  a_dout: assert property (p_dout) else $error("read data moved off falling clock");
  property p_quiet; mpiCsN[*4] |-> $stable(gainCfg); endproperty
  a_quiet: assert property (p_quiet) else $error("gain changed while idle");
endmodule
bind ccr_channel_regs ccr_channel_regs_chk u_chk (.sys_clk, .nrst, .mpiClk, .mpiCsN,
  .linePinIn, .muxSecondDetect, .e1MuxEnable, .mpiDout, .mpiDoutEn, .intPinOut, .intPinOe,
  .gainCfg, .loopbackEn,
  .scalingCutoff);

// ### ccr_host_model.sv
`timescale 1ns/1ps
module ccr_host_model (
  input  logic sys_clk,
  input  logic mpiDout,
  output logic mpiClk,
  output logic mpiCsN,
  output logic mpiDin
);
  initial begin
    mpiClk = 1'b1;
    mpiCsN = 1'b1;
    mpiDin = 1'b0;
  end
  // Levels held 5 cycles to clear the input synchronizer
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mpiClk = 1'b0;
      mpiDin = tx[i];
      repeat (5) @(negedge sys_clk);
      rx[i] = mpiDout;
      mpiClk = 1'b1;
      repeat (5) @(negedge sys_clk);
    end
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] unused;
    @(negedge sys_clk);
    mpiCsN = 1'b0;
    shift(cmd, unused);
    shift(wd, rd);
    mpiCsN = 1'b1;
    // Released line shows the inverse, never a stale copy
    mpiDin = ~mpiDin;
    repeat (5) @(negedge sys_clk);
  endtask
endmodule

// ### ccr_channel_regs_test.sv
`timescale 1ns/1ps
`include "ccr_channel_regs.vh"
module ccr_channel_regs_test;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [19:0] linePinIn = 20'h00000;
  logic [3:0]  chanActive = 4'h0;
  logic        clockSyncLost = 1'b0;
  logic [3:0]  muxSecondDetect = 4'h0;
  logic        e1MuxEnable = 1'b0;
  logic        mpiClk, mpiCsN, mpiDin, mpiDout, mpiDoutEn, intPinOut, intPinOe;
  logic [31:0] gainCfg, opFuncCfg;
  logic [3:0]  loopbackEn, scalingCutoff;
  logic [19:0] linePinOut, linePinOe;
  logic [7:0]  ctrlPinOut, rd;
  int          failCount = 0;
  int          numChecks = 0;
  int          cycles = 0;
  always #2.5 sys_clk = ~sys_clk;
  ccr_channel_regs u_dut (.sys_clk, .nrst, .mpiClk, .mpiCsN, .mpiDin, .linePinIn,
    .muxSecondDetect, .e1MuxEnable, .chanActive, .clockSyncLost, .mpiDout,
    .mpiDoutEn, .intPinOut, .intPinOe, .gainCfg, .opFuncCfg, .loopbackEn, .scalingCutoff,
    .linePinOut, .linePinOe, .ctrlPinOut);
  ccr_host_model u_host (.sys_clk, .mpiDout, .mpiClk, .mpiCsN, .mpiDin);
  task automatic finalReport();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    u_host.xfer(cmd, d, rd);
  endtask
  task automatic rdChk(input logic [7:0] cmd, input logic [7:0] exp);
    u_host.xfer(cmd | 8'h01, 8'h00, rd);
    check($sformatf("read %h", cmd), exp, rd);
  endtask
  // Whole run is about 5200 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      $display("mismatch timeout expected end seen hang");
      finalReport();
    end
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("cutoff", 8'h0f, {4'h0, scalingCutoff});
    rdChk(`CCR_CMD_GAIN, `CCR_RST_ZERO);
    rdChk(`CCR_CMD_LINEDATA, `CCR_RST_ZERO);
    rdChk(`CCR_CMD_DIR, `CCR_RST_ZERO);
    rdChk(`CCR_CMD_OPFUNC, `CCR_RST_ZERO);
    rdChk(`CCR_CMD_MASK, `CCR_RST_MASK);
    wr(`CCR_CMD_GAIN, 8'h10);
    check("loopback", 8'h0f, {4'h0, loopbackEn});
    check("cutoff", 8'h00, {4'h0, scalingCutoff});
    wr(`CCR_CMD_GAIN, 8'he1);
    rdChk(`CCR_CMD_GAIN, 8'he1);
    check("gain", 8'he1, gainCfg[31:24]);
    wr(`CCR_CMD_CHANEN, 8'h02);
    wr(`CCR_CMD_GAIN, 8'h35);
    check("gain0", 8'he1, gainCfg[7:0]);
    check("gain1", 8'h35, gainCfg[15:8]);
    wr(`CCR_CMD_CHANEN, 8'h00);
    wr(`CCR_CMD_MASK, 8'hfe);
    rdChk(`CCR_CMD_MASK, 8'hfe);
    rdChk(`CCR_CMD_GAIN, 8'h00);
    wr(`CCR_CMD_CHANEN, 8'h0f);
    rdChk(`CCR_CMD_CHANEN, 8'h0f);
    wr(`CCR_CMD_LINEDATA, 8'hde);
    wr(`CCR_CMD_DIR, 8'h14);
    check("drive", 8'h14, {3'h0, linePinOut[4:0] & linePinOe[4:0]});
    check("dir", 8'h14, {3'h0, linePinOe[19:15]});
    check("ctrl", 8'h03, {6'h00, ctrlPinOut[1:0]});
    rdChk(`CCR_CMD_LINEDATA, 8'hde);
    chanActive = 4'h1;
    clockSyncLost = 1'b1;
    rdChk(`CCR_CMD_DIR, 8'h74);
    wr(`CCR_CMD_CHANEN, 8'h00);
    rdChk(`CCR_CMD_DIR, 8'h20);
    wr(`CCR_CMD_CHANEN, 8'h0f);
    wr(`CCR_CMD_OPFUNC, 8'hc5);
    rdChk(`CCR_CMD_OPFUNC, 8'hc5);
    wr(`CCR_CMD_OPFUNC, 8'h3a);
    check("opfunc", 8'h3a, opFuncCfg[31:24]);
    linePinIn[1] = 1'b1;
    repeat (8) @(negedge sys_clk);
    check("irq masked", 8'h00, {7'h00, intPinOe});
    linePinIn[0] = 1'b1;
    repeat (8) @(negedge sys_clk);
    check("irq", 8'h01, {7'h00, intPinOe});
    rdChk(`CCR_CMD_RTDATA, 8'h03);
    check("irq held", 8'h01, {7'h00, intPinOe});
    rdChk(`CCR_CMD_RTCLEAR, 8'h03);
    check("irq clear", 8'h00, {7'h00, intPinOe});
    e1MuxEnable = 1'b1;
    muxSecondDetect = 4'h4;
    rdChk(`CCR_CMD_RTDATA, 8'h21);
    check("irq mux masked", 8'h00, {7'h00, intPinOe});
    wr(`CCR_CMD_MASK, 8'hdf);
    muxSecondDetect = 4'h0;
    repeat (8) @(negedge sys_clk);
    check("irq mux", 8'h01, {7'h00, intPinOe});
    rdChk(`CCR_CMD_RTCLEAR, 8'h01);
    check("irq mux clear", 8'h00, {7'h00, intPinOe});
    finalReport();
  end
endmodule
